//--- design/brc_regs.svh
/*
  constants of the brew run-control block: timing figures, parameter
  indices, limits, defaults, group ids and beep counts.
  assumes: included by bare name, definitions only.
*/
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH

// timing, each figure in its own unit
`define BRC_CLK_KHZ     40000
`define BRC_LONG_MS     5000
`define BRC_DEB_MS      10
`define BRC_MSG_MS      1000
`define BRC_BEEP_S_MS   100
`define BRC_BEEP_L_MS   500
`define BRC_PAIR_GAP_MS 1000
`define BRC_FAST_MS     50

// parameter indices; apb byte address is index times four
`define BRC_P_OFS    4'h0
`define BRC_P_UNIT   4'h1
`define BRC_P_PUS    4'h2
`define BRC_P_TF     4'h3
`define BRC_P_BTSP   4'h4
`define BRC_P_TSP    4'h5
`define BRC_P_EO     4'h6
`define BRC_P_OVERSHOOT_TRIM   4'h7
`define BRC_P_MBST   4'h8
`define BRC_P_DAMP   4'h9
`define BRC_NPARAM   4'hA
`define BRC_A_STATUS 6'h10

// limits and reset defaults, 16-bit two's complement
`define BRC_ZERO     16'h0000
`define BRC_ONE      16'h0001
`define BRC_OFS_LO   16'hFF9C
`define BRC_OFS_HI   16'h0064
`define BRC_T_LO     16'hFC19
`define BRC_T_HI     16'h270F
`define BRC_BTSP_DEF 16'h00D0
`define BRC_OVERSHOOT_TRIM_LO  16'hFFCE
`define BRC_OVERSHOOT_TRIM_HI  16'h0032
`define BRC_PCT_HI   16'h0064
`define BRC_DAMP_LO  16'hFFFE
`define BRC_DAMP_HI  16'h0002
`define BRC_FAST_STEP 16'h000A

// menu groups, in knob order
`define BRC_G_MASH 3'h0
`define BRC_G_STEP_TABLE_GROUP 3'h1
`define BRC_G_BOIL 3'h2
`define BRC_G_RELAY_PARAM_GROUP 3'h3
`define BRC_G_CONFIG_GROUP 3'h4

// beep counts; the long pause falls when this many beeps remain
`define BRC_NB_START  3'h2
`define BRC_NB_MARGIN 3'h3
`define BRC_NB_STEP   3'h4
`define BRC_NB_END    3'h6
`define BRC_NB_SPLIT  3'h2

`endif

//--- design/brc_pkg.sv
/*
  types of the brew run-control block: program, menu and message
  states, the parameter carrier and the status carrier.
  assumes: nothing beyond a sv compiler.
*/
package brc_pkg;

  typedef enum logic [1:0] {RUN_STOP, RUN_GO, RUN_HOLD} brc_run_type;
  typedef enum logic [1:0] {MENU_OFF, MENU_GROUP, MENU_EDIT} brc_menu_type;
  typedef enum logic [2:0] {
    MSG_NONE, MSG_RUN, MSG_STOP, MSG_HOLD, MSG_END
  } brc_msg_type;

  typedef struct packed {
    logic [15:0] ofs;
    logic        unit_f;
    logic        pus_inst;
    logic        tf_on;
    logic [15:0] btsp;
    logic [15:0] tsp;
    logic        eo_on;
    logic [15:0] overshoot_trim;
    logic [15:0] mbst;
    logic [15:0] damp;
  } brc_param_type;

  typedef struct packed {
    brc_run_type  run;
    brc_menu_type menu;
    brc_msg_type  msg;
    logic         heater;
    logic         boost;
    logic         timer_run;
    logic         timer_armed;
    logic         mash_count;
    logic         top_alt_time;
    logic         bot_alt_step;
    logic         top_alt_end;
    logic         beep;
  } brc_status_type;

endpackage

//--- design/brc_ctrl.sv
/*
  brew run-control sequencer: keys, knob menu, heater gating, timer
  start/hold/stop, beeps, parameter store with apb access.
  assumes: inputs synchronous to pclk, knob_cw/knob_ccw one-cycle pulses
  from an outside quadrature decoder, nv memory outside that echoes
  stored words back through nv_ld_* and then raises nv_ready.
*/
// Notes on behaviour
// - timer off: A runs heater, B stops
// - timer on: A runs, resumes or restarts
// - deferred start: A press also arms timer
// - timer on: B short holds timer only
// - B held 5 s stops timer and heater
// - timer starts: enabled, running, above threshold
// - timer start sounds two beeps
// - hold before start: starts already held
// - knob held 5 s opens group menu
// - knob turns edit value, press advances
// - parameters written through to nv memory
// - shown temperature is reading plus offset
// - unit choice, Fahrenheit by default
// - power-up: deferred stops, immediate runs
// - mode switch stops the program
// - mash count waits for start margin
// - step end: 2+2 beeps then boost
// - margin reached: three beeps, show time
// - mash end: six long beeps, end message
// - after mash end heater follows end option
// - overshoot trim only before first reach
// - damping limited to -2..+2
// - boil start threshold defaults to 208
`timescale 1ns/1ps
`default_nettype none
`include "brc_regs.svh"

module brc_ctrl #(
  parameter int LONG_CYC  = `BRC_LONG_MS * `BRC_CLK_KHZ,
  parameter int DEB_CYC   = `BRC_DEB_MS * `BRC_CLK_KHZ,
  parameter int MSG_CYC   = `BRC_MSG_MS * `BRC_CLK_KHZ,
  parameter int BS_CYC    = `BRC_BEEP_S_MS * `BRC_CLK_KHZ,
  parameter int BL_CYC    = `BRC_BEEP_L_MS * `BRC_CLK_KHZ,
  parameter int GAP_CYC   = `BRC_PAIR_GAP_MS * `BRC_CLK_KHZ,
  parameter int FAST_CYC  = `BRC_FAST_MS * `BRC_CLK_KHZ,
  parameter int CW        = 28
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   key_a,
  input  wire logic                   key_b,
  input  wire logic                   knob_press,
  input  wire logic                   knob_cw,
  input  wire logic                   knob_ccw,
  input  wire logic                   mode_mash,
  input  wire logic [15:0]            reading,
  input  wire logic [15:0]            step_setpoint,
  input  wire logic                   step_done,
  input  wire logic                   step_table_group_end,
  input  wire logic                   nv_ld_en,
  input  wire logic [3:0]             nv_ld_idx,
  input  wire logic [15:0]            nv_ld_val,
  input  wire logic                   nv_ready,
  output logic                        nv_wr_en,
  output logic [3:0]                  nv_wr_idx,
  output logic [15:0]                 nv_wr_val,
  output brc_pkg::brc_param_type      params,
  output brc_pkg::brc_status_type     status,
  output logic [15:0]                 disp_temp,
  output logic [15:0]                 trim_eff,
  output logic [2:0]                  menu_group,
  output logic [3:0]                  menu_param
);

  localparam logic [CW-1:0] LONG_T = CW'(LONG_CYC);
  localparam logic [CW-1:0] LONG_M = CW'(LONG_CYC - 1);
  localparam logic [CW-1:0] DEB_M  = CW'(DEB_CYC - 1);
  localparam logic [CW-1:0] MSG_T  = CW'(MSG_CYC);
  localparam logic [CW-1:0] BS_M   = CW'(BS_CYC - 1);
  localparam logic [CW-1:0] BL_M   = CW'(BL_CYC - 1);
  localparam logic [CW-1:0] GAP_M  = CW'(GAP_CYC - 1);
  localparam logic [CW-1:0] FAST_T = CW'(FAST_CYC);

  // sign-extend a 16-bit word for compare and step arithmetic
  function automatic logic signed [16:0] sx(input logic [15:0] v);
    sx = $signed({v[15], v});
  endfunction

  // per-parameter {low limit, high limit, reset default}
  function automatic logic [47:0] ptab(input logic [3:0] i);
    unique case (i)
      `BRC_P_OFS:  ptab = {`BRC_OFS_LO, `BRC_OFS_HI, `BRC_ZERO};
      `BRC_P_UNIT: ptab = {`BRC_ZERO, `BRC_ONE, `BRC_ONE};
      `BRC_P_PUS:  ptab = {`BRC_ZERO, `BRC_ONE, `BRC_ZERO};
      `BRC_P_TF:   ptab = {`BRC_ZERO, `BRC_ONE, `BRC_ONE};
      `BRC_P_BTSP: ptab = {`BRC_T_LO, `BRC_T_HI, `BRC_BTSP_DEF};
      `BRC_P_TSP:  ptab = {`BRC_T_LO, `BRC_T_HI, `BRC_ONE};
      `BRC_P_EO:   ptab = {`BRC_ZERO, `BRC_ONE, `BRC_ZERO};
      `BRC_P_OVERSHOOT_TRIM: ptab = {`BRC_OVERSHOOT_TRIM_LO, `BRC_OVERSHOOT_TRIM_HI, `BRC_ZERO};
      `BRC_P_MBST: ptab = {`BRC_ZERO, `BRC_PCT_HI, `BRC_PCT_HI};
      `BRC_P_DAMP: ptab = {`BRC_DAMP_LO, `BRC_DAMP_HI, `BRC_ZERO};
      default:     ptab = {`BRC_ZERO, `BRC_ZERO, `BRC_ZERO};
    endcase
  endfunction

  // out-of-range values are pinned to the nearer limit, not refused
  function automatic logic [15:0] clamp(input logic signed [16:0] v,
                                        input logic [3:0] i);
    logic [47:0] t;
    t = ptab(i);
    if (v < sx(t[47:32])) clamp = t[47:32];
    else if (v > sx(t[31:16])) clamp = t[31:16];
    else clamp = v[15:0];
  endfunction

  // menu group to {has parameters, first index, last index}
  function automatic logic [8:0] gsel(input logic [2:0] g);
    unique case (g)
      `BRC_G_MASH: gsel = {1'b1, `BRC_P_TSP, `BRC_P_DAMP};
      `BRC_G_BOIL: gsel = {1'b1, `BRC_P_TF, `BRC_P_BTSP};
      `BRC_G_CONFIG_GROUP: gsel = {1'b1, `BRC_P_OFS, `BRC_P_PUS};
      default:     gsel = {1'b0, `BRC_P_OFS, `BRC_P_OFS};
    endcase
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // debounce and press classing, lanes: 0 key A, 1 key B, 2 knob
  logic [2:0]    raw_w, deb_q, prv_q, long_w, short_w;
  logic [CW-1:0] dcnt_q [3];
  logic [CW-1:0] hcnt_q [3];
  assign raw_w = {knob_press, key_b, key_a};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_press
      assign long_w[gi]  = deb_q[gi] && hcnt_q[gi] == LONG_M;
      assign short_w[gi] = prv_q[gi] && !deb_q[gi] && hcnt_q[gi] != LONG_T;
    end
  endgenerate

  // a level must stand DEB_CYC cycles before it counts; bounce costs delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_q <= 3'h0;
      prv_q <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        dcnt_q[i] <= '0;
        hcnt_q[i] <= '0;
      end
    end else begin
      prv_q <= deb_q;
      for (int i = 0; i < 3; i++) begin
        if (raw_w[i] == deb_q[i]) dcnt_q[i] <= '0;
        else if (dcnt_q[i] == DEB_M) begin
          deb_q[i]  <= raw_w[i];
          dcnt_q[i] <= '0;
        end else dcnt_q[i] <= dcnt_q[i] + 1'b1;
        if (!deb_q[i]) hcnt_q[i] <= '0;
        else if (hcnt_q[i] != LONG_T) hcnt_q[i] <= hcnt_q[i] + 1'b1;
      end
    end
  end

  // knob speed: a turn soon after the last one steps ten at a time
  logic [CW-1:0] gap_q;
  logic          rot_w;
  logic [15:0]   step_w;
  assign rot_w  = knob_cw | knob_ccw;
  assign step_w = (gap_q < FAST_T) ? `BRC_FAST_STEP : `BRC_ONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= LONG_T;
    else if (rot_w) gap_q <= '0;
    else if (gap_q != LONG_T) gap_q <= gap_q + 1'b1;
  end

  // menu navigation
  brc_pkg::brc_menu_type menu_q;
  logic [2:0]            grp_q, grp_nx_w;
  logic [3:0]            idx_q;
  logic [8:0]            gs_w;
  assign gs_w     = gsel(grp_q);
  assign grp_nx_w = knob_cw ? ((grp_q == `BRC_G_CONFIG_GROUP) ? `BRC_G_MASH
                                                      : grp_q + 3'h1)
                  : knob_ccw ? ((grp_q == `BRC_G_MASH) ? `BRC_G_CONFIG_GROUP
                                                       : grp_q - 3'h1)
                  : grp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_q <= brc_pkg::MENU_OFF;
      grp_q  <= `BRC_G_MASH;
      idx_q  <= `BRC_P_OFS;
    end else begin
      unique case (menu_q)
        brc_pkg::MENU_OFF: if (long_w[2]) begin
          menu_q <= brc_pkg::MENU_GROUP;
          grp_q  <= `BRC_G_MASH;
        end
        brc_pkg::MENU_GROUP: begin
          grp_q <= grp_nx_w;
          if (short_w[2]) begin
            menu_q <= gs_w[8] ? brc_pkg::MENU_EDIT : brc_pkg::MENU_OFF;
            idx_q  <= gs_w[7:4];
          end
        end
        brc_pkg::MENU_EDIT: if (short_w[2]) begin
          if (idx_q == gs_w[3:0]) menu_q <= brc_pkg::MENU_OFF;
          else idx_q <= idx_q + 4'h1;
        end
        default: menu_q <= brc_pkg::MENU_OFF;
      endcase
    end
  end

  // parameter store: apb first, then knob edit, then nv restore
  logic [15:0]         params_q [`BRC_NPARAM];
  logic [3:0]          pidx_w, wr_idx_w;
  logic                acc_w, phit_w, shit_w, pw_w, ed_w, wr_en_w;
  logic signed [16:0]  ed_val_w, wr_raw_w;
  logic [15:0]         wr_val_w;
  assign acc_w   = psel && penable;
  assign pidx_w  = paddr[5:2];
  assign phit_w  = paddr[1:0] == 2'h0 && paddr[7:2] < 6'(`BRC_NPARAM);
  assign shit_w  = paddr[1:0] == 2'h0 && paddr[7:2] == `BRC_A_STATUS;
  assign pw_w    = acc_w && pwrite && phit_w;
  assign ed_w    = menu_q == brc_pkg::MENU_EDIT && rot_w;
  assign ed_val_w = knob_cw ? sx(params_q[idx_q]) + sx(step_w)
                            : sx(params_q[idx_q]) - sx(step_w);
  assign wr_idx_w = pw_w ? pidx_w : ed_w ? idx_q : nv_ld_idx;
  assign wr_raw_w = pw_w ? sx(pwdata[15:0]) : ed_w ? ed_val_w
                                                   : sx(nv_ld_val);
  assign wr_en_w  = pw_w || ed_w || (nv_ld_en && nv_ld_idx < `BRC_NPARAM);
  assign wr_val_w = clamp(wr_raw_w, wr_idx_w);

  // every apb or knob change is echoed to nv so it outlives power-off; nv restores are not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `BRC_NPARAM; i++)
        params_q[i] <= 16'(ptab(4'(i)));
      nv_wr_en  <= 1'b0;
      nv_wr_idx <= `BRC_P_OFS;
      nv_wr_val <= `BRC_ZERO;
    end else begin
      if (wr_en_w) params_q[wr_idx_w] <= wr_val_w;
      nv_wr_en  <= pw_w || ed_w;
      nv_wr_idx <= wr_idx_w;
      nv_wr_val <= wr_val_w;
    end
  end

  assign params = '{ofs: params_q[`BRC_P_OFS],
                    unit_f: params_q[`BRC_P_UNIT][0],
                    pus_inst: params_q[`BRC_P_PUS][0],
                    tf_on: params_q[`BRC_P_TF][0],
                    btsp: params_q[`BRC_P_BTSP],
                    tsp: params_q[`BRC_P_TSP],
                    eo_on: params_q[`BRC_P_EO][0],
                    overshoot_trim: params_q[`BRC_P_OVERSHOOT_TRIM],
                    mbst: params_q[`BRC_P_MBST],
                    damp: params_q[`BRC_P_DAMP]};

  // run control decode; a mode switch outranks every key
  brc_pkg::brc_run_type run_q, run_d;
  logic        pu_q, arm_q, tst_q, end_q, rch_q, ever_q, mode_q, bpend_q;
  logic [CW-1:0] msg_q;
  logic [2:0]    blft_q, bn_w;
  logic        mash_w, mchg_w, pu_go_w, a_go_w, b_hold_w, b_stop_w;
  logic        start_w, reach_w, end_w, stepd_w, within_w, above_w, heat_w;
  assign mash_w   = mode_mash;
  assign mchg_w   = mode_q != mode_mash;
  assign pu_go_w  = !pu_q && nv_ready;
  assign a_go_w   = pu_q && short_w[0];
  assign b_hold_w = pu_q && short_w[1];
  assign b_stop_w = pu_q && long_w[1];
  assign above_w  = sx(disp_temp) > sx(params.btsp);
  assign within_w = sx(disp_temp) >= sx(step_setpoint) - sx(params.tsp);
  assign start_w  = pu_q && !mchg_w && !mash_w && params.tf_on && arm_q &&
                    !tst_q && run_q != brc_pkg::RUN_STOP && above_w;
  assign reach_w  = mash_w && !rch_q && within_w &&
                    run_q != brc_pkg::RUN_STOP;
  assign end_w    = mash_w && step_table_group_end && !end_q &&
                    run_q != brc_pkg::RUN_STOP;
  assign stepd_w  = mash_w && step_done && run_q != brc_pkg::RUN_STOP;
  assign run_d = mchg_w ? brc_pkg::RUN_STOP
    : pu_go_w ? (params.pus_inst ? brc_pkg::RUN_GO
                                 : brc_pkg::RUN_STOP)
    : b_stop_w ? brc_pkg::RUN_STOP
    : a_go_w ? brc_pkg::RUN_GO
    : (b_hold_w && run_q == brc_pkg::RUN_GO && (params.tf_on || mash_w))
      ? brc_pkg::RUN_HOLD
    : (b_hold_w && !params.tf_on && !mash_w) ? brc_pkg::RUN_STOP
    : run_q;
  assign heat_w = pu_q && run_q != brc_pkg::RUN_STOP &&
                  !(end_q && !params.eo_on);

  // program state; hold keeps the heater, stop or a mash end with the end option off drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q   <= brc_pkg::RUN_STOP;
      pu_q    <= 1'b0;
      arm_q   <= 1'b0;
      tst_q   <= 1'b0;
      end_q   <= 1'b0;
      rch_q   <= 1'b0;
      ever_q  <= 1'b0;
      mode_q  <= 1'b0;
      bpend_q <= 1'b0;
      msg_q   <= '0;
    end else begin
      mode_q <= mode_mash;
      run_q  <= run_d;
      pu_q   <= pu_q || nv_ready;
      if (pu_go_w) arm_q <= params.pus_inst && params.tf_on;
      else if (a_go_w && params.tf_on && !params.pus_inst)
        arm_q <= 1'b1;
      if (mchg_w || b_stop_w) tst_q <= 1'b0;
      else if (start_w) tst_q <= 1'b1;
      if (mchg_w || (a_go_w && run_q == brc_pkg::RUN_STOP)) end_q <= 1'b0;
      else if (end_w) end_q <= 1'b1;
      if (mchg_w || stepd_w || run_d == brc_pkg::RUN_STOP) rch_q <= 1'b0;
      else if (reach_w) rch_q <= 1'b1;
      if (run_d == brc_pkg::RUN_STOP) ever_q <= 1'b0;
      else if (reach_w) ever_q <= 1'b1;
      if (stepd_w) bpend_q <= 1'b1;
      else if (blft_q == 3'h0) bpend_q <= 1'b0;
      if (a_go_w && !params.tf_on && !mash_w) msg_q <= MSG_T;
      else if (msg_q != '0) msg_q <= msg_q - 1'b1;
    end
  end

  // beeper: counted beeps, long gap after the first pair of a step end
  logic          bon_q, blng_q, bspl_q, bgo_w, bend_w;
  logic [CW-1:0] bcnt_q, bdur_w;
  assign bgo_w  = end_w || stepd_w || reach_w || start_w;
  assign bn_w   = end_w ? `BRC_NB_END : stepd_w ? `BRC_NB_STEP
                : reach_w ? `BRC_NB_MARGIN : `BRC_NB_START;
  assign bdur_w = bon_q ? (blng_q ? BL_M : BS_M)
                : (bspl_q && blft_q == `BRC_NB_SPLIT) ? GAP_M : BS_M;
  assign bend_w = bcnt_q == bdur_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blft_q <= 3'h0;
      bon_q  <= 1'b0;
      blng_q <= 1'b0;
      bspl_q <= 1'b0;
      bcnt_q <= '0;
    end else if (bgo_w) begin
      blft_q <= bn_w;
      bon_q  <= 1'b1;
      blng_q <= end_w;
      bspl_q <= stepd_w && !end_w;
      bcnt_q <= '0;
    end else if (blft_q != 3'h0) begin
      bcnt_q <= bend_w ? '0 : bcnt_q + 1'b1;
      if (bend_w) bon_q <= !bon_q;
      if (bend_w && bon_q) blft_q <= blft_q - 3'h1;
    end
  end

  // outputs, registered; trim only acts until the first reach
  brc_pkg::brc_status_type st_w;
  assign st_w = '{run: run_q, menu: menu_q,
    msg: (end_q && mash_w) ? brc_pkg::MSG_END
       : (run_q == brc_pkg::RUN_STOP) ? brc_pkg::MSG_STOP
       : (run_q == brc_pkg::RUN_HOLD) ? brc_pkg::MSG_HOLD
       : (msg_q != '0) ? brc_pkg::MSG_RUN : brc_pkg::MSG_NONE,
    heater: heat_w,
    boost: mash_w && heat_w && !rch_q && !bpend_q,
    timer_run: tst_q && run_q == brc_pkg::RUN_GO && !mash_w,
    timer_armed: arm_q,
    mash_count: mash_w && rch_q && run_q == brc_pkg::RUN_GO && !end_q,
    top_alt_time: mash_w && rch_q && !end_q,
    bot_alt_step: mash_w && !rch_q && run_q != brc_pkg::RUN_STOP,
    top_alt_end: mash_w && end_q,
    beep: bon_q && blft_q != 3'h0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status    <= '0;
      disp_temp <= `BRC_ZERO;
      trim_eff  <= `BRC_ZERO;
    end else begin
      status    <= st_w;
      disp_temp <= reading + params.ofs;
      trim_eff  <= ever_q ? `BRC_ZERO : params.overshoot_trim;
    end
  end

  // apb: zero wait states, unmapped addresses answer with pslverr
  assign pready     = 1'b1;
  assign pslverr    = acc_w && !phit_w && !shit_w;
  assign prdata     = (phit_w && !pwrite) ? 32'(params_q[pidx_w])
                    : (shit_w && !pwrite) ? 32'(status) : 32'h0000_0000;
  assign menu_group = grp_q;
  assign menu_param = idx_q;

  AST_STOP_NO_HEAT:
    assert property (status.run == brc_pkg::RUN_STOP |-> !status.heater)
    else $error("heater on while stopped");
  AST_B_HOLDS_TIMER:
    assert property (b_hold_w && !mchg_w && !b_stop_w && !a_go_w &&
                     params.tf_on && run_q == brc_pkg::RUN_GO
                     |=> run_q == brc_pkg::RUN_HOLD ##1 status.heater)
    else $error("short B did not hold with heater kept");
  AST_LONG_B_STOPS:
    assert property (b_stop_w && !mchg_w
                     |=> run_q == brc_pkg::RUN_STOP && !tst_q
                     ##1 !status.heater && !status.timer_run)
    else $error("long B did not stop timer and heater");
  AST_START_CAUSE:
    assert property ($rose(tst_q) |-> $past(above_w && params.tf_on &&
                     run_q != brc_pkg::RUN_STOP))
    else $error("timer started without its three conditions");
  AST_START_BEEP:
    assert property ($rose(tst_q) |-> bon_q ##1 status.beep)
    else $error("timer start gave no beep");
  AST_HELD_START:
    assert property ($rose(tst_q) && run_q == brc_pkg::RUN_HOLD
                     |=> !status.timer_run)
    else $error("held timer ran on start");
  AST_MODE_STOP:
    assert property (mchg_w |=> run_q == brc_pkg::RUN_STOP
                     ##1 status.msg == brc_pkg::MSG_STOP)
    else $error("mode switch did not stop");
  AST_OFS_RANGE:
    assert property (sx(params.ofs) >= sx(`BRC_OFS_LO) &&
                     sx(params.ofs) <= sx(`BRC_OFS_HI))
    else $error("offset outside its range");
  AST_DAMP_RANGE:
    assert property (sx(params.damp) >= sx(`BRC_DAMP_LO) &&
                     sx(params.damp) <= sx(`BRC_DAMP_HI))
    else $error("damping outside its range");
  AST_END_OFF:
    assert property (end_q && !params.eo_on |=> !status.heater)
    else $error("heater on after end with option off");

  COV_TIMER_START: cover property ($rose(tst_q));
  COV_MENU_EDIT:   cover property (menu_q == brc_pkg::MENU_EDIT && ed_w);
  COV_HOLD:        cover property (run_q == brc_pkg::RUN_HOLD);
  COV_MASH_END:    cover property ($rose(end_q));

endmodule
`default_nettype wire

//--- test/brc_operator.sv
/* operator model: presses key a, key b or the knob for a count of cycles.
   assumes: pclk from the bench; the block debounces raw levels. */
`timescale 1ns/1ps
`default_nettype none
module brc_operator (
  input  wire logic pclk,
  output logic      key_a,
  output logic      key_b,
  output logic      knob_press,
  output logic      knob_cw,
  output logic      knob_ccw
);
  initial begin
    key_a = 1'h0;
    key_b = 1'h0;
    knob_press = 1'h0;
    knob_cw = 1'h0;
    knob_ccw = 1'h0;
  end
  // hold one key n cycles, then stay released long enough to settle
  task automatic push(input int k, input int n);
    for (int i = 0; i < n + 12; i++) begin
      @(posedge pclk);
      key_a <= (k == 0) && (i < n);
      key_b <= (k == 1) && (i < n);
      knob_press <= (k == 2) && (i < n);
    end
  endtask
  // one detent: a single-cycle pulse, as the outside decoder gives it
  task automatic turn(input logic cw);
    @(posedge pclk);
    knob_cw <= cw;
    knob_ccw <= !cw;
    @(posedge pclk);
    {knob_cw, knob_ccw} <= 2'h0;
  endtask
endmodule
`default_nettype wire

//--- test/brew_run_control_tb.sv
/* bench: parameter store over apb, boil-mode key sequences, mode switch.
   assumes: brc_pkg and the operator model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module brew_run_control_tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic        mode_mash = 1'h0;
  logic        nv_ready = 1'h0;
  logic        sd = 1'h0;
  logic        pe = 1'h0;
  logic [15:0] reading = 16'h0064;
  logic [15:0] setp = 16'h0064;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, key_a, key_b, knob_press;
  logic        knob_cw, knob_ccw, nv_wr_en;
  logic [2:0]  menu_group;
  logic [3:0]  nv_wr_idx, menu_param;
  logic [15:0] disp_temp, nv_wr_val, trim_eff;
  brc_pkg::brc_status_type status;
  brc_pkg::brc_param_type  params;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #12.5 pclk = ~pclk;

  // long counts shortened so a five second hold is forty cycles
  brc_ctrl #(.LONG_CYC(40), .DEB_CYC(4), .MSG_CYC(20), .BS_CYC(5),
    .BL_CYC(10), .GAP_CYC(15), .FAST_CYC(8)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_a(key_a), .key_b(key_b),
    .knob_press(knob_press), .knob_cw(knob_cw), .knob_ccw(knob_ccw),
    .mode_mash(mode_mash), .reading(reading), .step_setpoint(setp),
    .step_done(sd), .step_table_group_end(pe), .nv_ld_en(1'h0), .nv_ld_idx(4'h0),
    .nv_ld_val(16'h0000), .nv_ready(nv_ready), .nv_wr_en(nv_wr_en),
    .nv_wr_idx(nv_wr_idx), .nv_wr_val(nv_wr_val), .params(params),
    .status(status), .disp_temp(disp_temp), .trim_eff(trim_eff),
    .menu_group(menu_group), .menu_param(menu_param));
  brc_operator op (.pclk(pclk), .key_a(key_a), .key_b(key_b),
    .knob_press(knob_press), .knob_cw(knob_cw), .knob_ccw(knob_ccw));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one apb transfer; data and error are taken at the pready edge
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'h2, a, w, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (n == 20) miscompares++;
    if (n == 20) report_and_stop();
  endtask
  task automatic t_store();
    apb(1'h0, 8'h10, 32'h0);
    chk("btsp", 16'h00D0, rd[15:0]);
    apb(1'h0, 8'h04, 32'h0);
    chk("unit", 16'h0001, rd[15:0]);
    apb(1'h1, 8'h00, 32'h000000C8);
    apb(1'h0, 8'h00, 32'h0);
    chk("ofs", 16'h0064, rd[15:0]);
    apb(1'h1, 8'h1C, 32'h00000005);
    wt(3);
    chk("disp", 16'h00C8, disp_temp);
    chk("trim", 16'h0005, trim_eff);
    apb(1'h1, 8'h24, 32'h00000005);
    wt(0);
    chk("nv idx", 16'h0009, nv_wr_idx);
    chk("nv en", 16'h0001, nv_wr_en);
    apb(1'h0, 8'h24, 32'h0);
    chk("damp", 16'h0002, rd[15:0]);
    apb(1'h0, 8'h40, 32'h0);
    chk("status", 16'h0400, rd[15:0]);
    apb(1'h0, 8'h30, 32'h0);
    chk("slverr", 16'h0001, er);
    apb(1'h1, 8'h00, 32'h0);
  endtask
  task automatic t_boil();
    wt(3);
    chk("run", brc_pkg::RUN_STOP, status.run);
    chk("heat", 16'h0000, status.heater);
    op.push(0, 8);
    chk("run", brc_pkg::RUN_GO, status.run);
    chk("heat", 16'h0001, status.heater);
    chk("arm", 16'h0001, status.timer_armed);
    @(posedge pclk) reading <= 16'h00D1;
    wt(4);
    chk("tmr", 16'h0001, status.timer_run);
    chk("beep", 16'h0001, status.beep);
    op.push(1, 8);
    chk("run", brc_pkg::RUN_HOLD, status.run);
    chk("heat", 16'h0001, status.heater);
    op.push(1, 48);
    chk("run", brc_pkg::RUN_STOP, status.run);
    chk("heat", 16'h0000, status.heater);
    chk("tmr", 16'h0000, status.timer_run);
  endtask
  // hold before the threshold is crossed: timer starts already held
  task automatic t_early();
    @(posedge pclk) reading <= 16'h0064;
    op.push(0, 8);
    op.push(1, 8);
    chk("run", brc_pkg::RUN_HOLD, status.run);
    @(posedge pclk) reading <= 16'h00D1;
    wt(4);
    chk("beep", 16'h0001, status.beep);
    chk("tmr", 16'h0000, status.timer_run);
  endtask
  task automatic t_mode();
    @(posedge pclk) mode_mash <= 1'h1;
    wt(3);
    chk("run", brc_pkg::RUN_STOP, status.run);
    chk("heat", 16'h0000, status.heater);
  endtask
  // mash: reach, step end with boost after the beeps, program end
  task automatic t_mash();
    @(posedge pclk) setp <= 16'h00D1;
    op.push(0, 8);
    chk("alt", 16'h0001, status.top_alt_time);
    chk("trim", 16'h0000, trim_eff);
    @(posedge pclk) {setp, sd} <= {16'h0100, 1'h1};
    @(posedge pclk) sd <= 1'h0;
    wt(3);
    chk("boost", 16'h0000, status.boost);
    wt(60);
    chk("boost", 16'h0001, status.boost);
    chk("step", 16'h0001, status.bot_alt_step);
    @(posedge pclk) pe <= 1'h1;
    @(posedge pclk) pe <= 1'h0;
    wt(3);
    chk("heat", 16'h0000, status.heater);
    chk("end", 16'h0001, status.top_alt_end);
  endtask
  // knob menu: long press, two detents to boil, slow then fast edit
  task automatic t_menu();
    op.push(2, 48);
    op.turn(1'h1);
    op.turn(1'h1);
    wt(0);
    chk("group", 16'h0002, menu_group);
    op.push(2, 8);
    op.push(2, 8);
    chk("param", 16'h0004, menu_param);
    op.turn(1'h1);
    op.turn(1'h1);
    wt(0);
    chk("btsp", 16'h00DB, params.btsp);
    chk("nv val", 16'h00DB, nv_wr_val);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_store();
    @(posedge pclk) nv_ready <= 1'h1;
    t_boil();
    t_early();
    t_mode();
    t_mash();
    t_menu();
    report_and_stop();
  end
  initial begin
    #2500000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
